// ==== pkg/fsp_pkg.sv ====
package fsp_pkg;
    // ----------------------------------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0]  FSP_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  FSP_OFS_STATUS  = 8'h04;
    localparam logic [7:0]  FSP_OFS_PAGE    = 8'h08;
    // Control field positions
    localparam int          FSP_B_ENABLE    = 0;
    localparam int          FSP_B_CLEAR     = 4;
    // Status field positions
    localparam int          FSP_S_BUSY      = 0;
    localparam int          FSP_S_ARMED     = 1;
    localparam int          FSP_S_EEBUSY    = 2;
    localparam int          FSP_S_LOADED    = 3;
    // Accepted control codes and the reset value, lower five bits
    localparam logic [4:0]  FSP_CMD_LOAD    = 5'h01;
    localparam logic [4:0]  FSP_CMD_ERASE   = 5'h03;
    localparam logic [4:0]  FSP_CMD_WRITE   = 5'h05;
    localparam logic [4:0]  FSP_CMD_FLREAD  = 5'h09;
    localparam logic [4:0]  FSP_CMD_CLEAR   = 5'h11;
    localparam logic [4:0]  FSP_CTRL_RESET  = 5'h00;
    // Instruction windows in clock cycles
    localparam logic [2:0]  FSP_SPM_WINDOW  = 3'h4;
    localparam logic [2:0]  FSP_LPM_WINDOW  = 3'h3;
    // Fuse and lock read decode
    localparam int          FSP_FUSE_SPM_BIT = 4;
    localparam logic [15:0] FSP_Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] FSP_Z_LOCK      = 16'h0001;
    localparam logic [15:0] FSP_Z_FUSE_HIGH = 16'h0003;
    localparam logic [7:0]  FSP_UNDEF_BYTE  = 8'hff;
    // Flash page organisation and erased contents
    localparam int          FSP_WORD_BITS   = 4;
    localparam logic [15:0] FSP_ERASED_WORD = 16'hffff;
    // Operation timing
    localparam int          FSP_CLK_PERIOD_NS = 10;
    localparam int          FSP_TICK_NS     = 1000;
    localparam int          FSP_OP_MIN_NS   = 3700000;
    localparam int          FSP_OP_MAX_NS   = 4500000;
    localparam int          FSP_TICK_DIV    = FSP_TICK_NS / FSP_CLK_PERIOD_NS;
    localparam int          FSP_OP_TICKS    = (FSP_OP_MIN_NS + FSP_TICK_NS - 1) / FSP_TICK_NS;
    // Bus responses
    localparam logic [1:0]  FSP_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  FSP_RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/fsp_op_timer.sv ====
`timescale 1ns/1ps
module fsp_op_timer #(
    parameter int TICK_DIV = fsp_pkg::FSP_TICK_DIV,
    parameter int OP_TICKS = fsp_pkg::FSP_OP_TICKS
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Operation control
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    import fsp_pkg::*;

    typedef struct packed {
        logic [15:0] div;
        logic [15:0] ticks;
        logic        busy;
        logic        done;
    } fsp_tmr_t;

    fsp_tmr_t s_q;
    fsp_tmr_t s_d;

    // ----------------------------------------------------------------
    // Oscillator tick prescaler and duration counter
    // ----------------------------------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy) begin
            if (start) begin
                s_d.busy  = 1'b1;
                s_d.div   = '0;
                s_d.ticks = '0;
            end
        end else if (s_q.div == 16'(TICK_DIV - 1)) begin
            s_d.div = '0;
            if (s_q.ticks == 16'(OP_TICKS - 1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.ticks = s_q.ticks + 16'h0001;
            end
        end else begin
            s_d.div = s_q.div + 16'h0001;
        end
    end

    // Reset leaves a running operation to finish
    always_ff @(posedge mclk) begin
        if (reset && s_q.busy) begin
            s_q <= s_d;
        end else if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// ==== hdl/fsp_page_buffer.sv ====
`timescale 1ns/1ps
module fsp_page_buffer #(
    parameter int WORD_BITS = fsp_pkg::FSP_WORD_BITS,
    parameter int DATA_W    = 16
) (
    // Clock and clear
    input  wire logic                 mclk,
    input  wire logic                 clr,
    // Word load port
    input  wire logic                 wr_en,
    input  wire logic [WORD_BITS-1:0] wr_idx,
    input  wire logic [DATA_W-1:0]    wr_data,
    // Flash read port
    input  wire logic [WORD_BITS-1:0] rd_idx,
    output logic      [DATA_W-1:0]    rd_data,
    output logic                      loaded
);
    import fsp_pkg::*;

    localparam int WORDS = 1 << WORD_BITS;

    typedef struct packed {
        logic [WORDS-1:0][DATA_W-1:0] mem;
        logic [WORDS-1:0]             vld;
        logic [DATA_W-1:0]            rdata;
        logic                         any;
    } fsp_buf_t;

    fsp_buf_t s_q;
    fsp_buf_t s_d;

    // ----------------------------------------------------------------
    // Word storage, random order loading, clear, registered read
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (clr) begin
            s_d.vld = '0;
        end else if (wr_en) begin
            s_d.mem[wr_idx] = wr_data;
            s_d.vld[wr_idx] = 1'b1;
        end
        s_d.any   = |s_d.vld;
        s_d.rdata = s_q.vld[rd_idx] ? s_q.mem[rd_idx] : DATA_W'(FSP_ERASED_WORD);
    end

    // State register
    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    assign rd_data = s_q.rdata;
    assign loaded  = s_q.any;
endmodule

// ==== hdl/fsp_self_prog.sv ====
// Functional notes
// - Store-program does nothing unless the self-program fuse bit reads zero.
// - Buffer loads one word per store-program, before erase or between erase and write.
// - Buffer words may be loaded in any address order.
// - Code 00000011 then store-program within four cycles erases the pointer's page.
// - CPU stalls for the whole page erase.
// - Code 00000001 then store-program within four cycles loads data word at word field.
// - Buffer clears after page write, on clear-buffer command and on reset; a reset during a page write keeps it until the write ends.
// - An EEPROM write during loading discards the buffer.
// - Code 00000101 then store-program within four cycles writes the pointer's page.
// - CPU stalls for the whole page write.
// - Pointer low bits pick the word, upper bits pick the page.
// - Fuse reads use pointer bit zero; store-program ignores it.
// - EEPROM write busy blocks flash programming and fuse or lock reads.
// - Pointer 0x0001, read select, load-program within three cycles returns lock byte.
// - Read select and enable clear on read done or missed window.
// - Pointer 0x0000 gives fuse low, 0x0003 fuse high, 0x0001 lock byte.
// - A flash operation running at reset still completes.
// - Erase and write last between 3.7 ms and 4.5 ms, timed by oscillator.
// - Only five legal control codes take effect; others are ignored.
// - Erase and write bits clear at completion or missed window.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fsp_self_prog #(
    parameter int WORD_BITS = fsp_pkg::FSP_WORD_BITS,
    parameter int TICK_DIV  = fsp_pkg::FSP_TICK_DIV,
    parameter int OP_TICKS  = fsp_pkg::FSP_OP_TICKS
) (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // AXI4-Lite write channels
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // CPU instruction side
    input  wire logic                    spm_strobe,
    input  wire logic                    lpm_strobe,
    input  wire logic [15:0]             z_pointer,
    input  wire logic [15:0]             data_word,
    output logic                         cpu_stall,
    output logic [7:0]                   lpm_data,
    output logic                         lpm_fuse_valid,
    // Fuse, lock and EEPROM status
    input  wire logic                    eeprom_write_busy,
    input  wire logic [7:0]              fuse_low_byte,
    input  wire logic [7:0]              fuse_high_byte,
    input  wire logic [7:0]              lock_byte,
    // Flash array side
    output logic                         flash_erase,
    output logic                         flash_write,
    output logic [14-WORD_BITS:0]        flash_page,
    input  wire logic [WORD_BITS-1:0]    flash_buf_idx,
    output logic [15:0]                  flash_buf_data
);
    import fsp_pkg::*;

    localparam int PAGE_BITS = 15 - WORD_BITS;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ARMED = 4'h2,
        ST_ERASE = 4'h4,
        ST_WRITE = 4'h8
    } fsp_phase_t;

    typedef struct packed {
        fsp_phase_t           phase;
        logic [4:0]           ctrl;
        logic [2:0]           window;
        logic [PAGE_BITS-1:0] page;
        logic                 stall;
        logic                 erase;
        logic                 write;
        logic [7:0]           lpm_data;
        logic                 lpm_valid;
        logic                 ee_busy;
        logic                 awready;
        logic                 aw_have;
        logic [7:0]           waddr;
        logic                 wready;
        logic                 w_have;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } fsp_top_t;

    fsp_top_t s_q;
    fsp_top_t s_d;
    logic     tmr_start;
    logic     tmr_done;
    logic     buf_wr;
    logic     buf_clr;
    logic     buf_loaded;
    logic     wr_go;
    logic     spm_go;
    logic     lpm_go;
    logic     op_run;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Legal control codes
    function automatic logic ctrl_ok(input logic [4:0] code);
        return code == FSP_CMD_LOAD || code == FSP_CMD_ERASE || code == FSP_CMD_WRITE ||
               code == FSP_CMD_FLREAD || code == FSP_CMD_CLEAR;
    endfunction

    // Page and word fields of the pointer, bit zero dropped
    function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] z);
        return z[15:WORD_BITS+1];
    endfunction

    function automatic logic [WORD_BITS-1:0] word_of(input logic [15:0] z);
        return z[WORD_BITS:1];
    endfunction

    // Fuse and lock byte by full pointer
    function automatic logic [7:0] fuse_sel(input logic [15:0] z);
        case (z)
            FSP_Z_FUSE_LOW:  return fuse_low_byte;
            FSP_Z_LOCK:      return lock_byte;
            FSP_Z_FUSE_HIGH: return fuse_high_byte;
            default:         return FSP_UNDEF_BYTE;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    fsp_op_timer #(
        .TICK_DIV (TICK_DIV),
        .OP_TICKS (OP_TICKS)
    ) u_timer (
        .mclk  (mclk),
        .reset (reset),
        .start (tmr_start),
        .busy  (),
        .done  (tmr_done)
    );

    fsp_page_buffer #(
        .WORD_BITS (WORD_BITS),
        .DATA_W    (16)
    ) u_buffer (
        .mclk    (mclk),
        .clr     (buf_clr),
        .wr_en   (buf_wr),
        .wr_idx  (word_of(z_pointer)),
        .wr_data (data_word),
        .rd_idx  (flash_buf_idx),
        .rd_data (flash_buf_data),
        .loaded  (buf_loaded)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Qualified requests
    assign op_run = s_q.phase == ST_ERASE || s_q.phase == ST_WRITE;
    assign wr_go  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    assign spm_go = spm_strobe && s_q.phase == ST_ARMED && s_q.ctrl != FSP_CMD_FLREAD &&
                    !fuse_high_byte[FSP_FUSE_SPM_BIT] && !eeprom_write_busy;
    assign lpm_go = lpm_strobe && s_q.phase == ST_ARMED && s_q.ctrl == FSP_CMD_FLREAD &&
                    !eeprom_write_busy;

    always_comb begin
        s_d           = s_q;
        s_d.lpm_valid = 1'b0;
        s_d.ee_busy   = eeprom_write_busy;
        tmr_start     = 1'b0;
        buf_wr        = 1'b0;
        buf_clr       = 1'b0;
        // Bus write address and data capture
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Command window runs out
        if (s_q.phase == ST_ARMED) begin
            s_d.window = s_q.window - 3'h1;
            if (s_q.window == 3'h1) begin
                s_d.ctrl  = FSP_CTRL_RESET;
                s_d.phase = ST_IDLE;
            end
        end
        // Store-program instruction
        if (spm_go) begin
            s_d.ctrl  = FSP_CTRL_RESET;
            s_d.phase = ST_IDLE;
            case (s_q.ctrl)
                FSP_CMD_LOAD: begin
                    buf_wr = 1'b1;
                end
                FSP_CMD_ERASE: begin
                    s_d.ctrl  = s_q.ctrl;
                    s_d.phase = ST_ERASE;
                    s_d.page  = page_of(z_pointer);
                    tmr_start = 1'b1;
                end
                FSP_CMD_WRITE: begin
                    s_d.ctrl  = s_q.ctrl;
                    s_d.phase = ST_WRITE;
                    s_d.page  = page_of(z_pointer);
                    tmr_start = 1'b1;
                end
                default: begin
                    s_d.ctrl = FSP_CTRL_RESET;
                end
            endcase
        end
        // Fuse and lock read by load-program
        if (lpm_go) begin
            s_d.lpm_data  = fuse_sel(z_pointer);
            s_d.lpm_valid = 1'b1;
            s_d.ctrl      = FSP_CTRL_RESET;
            s_d.phase     = ST_IDLE;
        end
        // Timed operation finished
        if (tmr_done) begin
            if (s_q.phase == ST_WRITE) begin
                buf_clr = 1'b1;
            end
            s_d.ctrl  = FSP_CTRL_RESET;
            s_d.phase = ST_IDLE;
        end
        // Register writes
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = FSP_RESP_OKAY;
            case (s_q.waddr)
                FSP_OFS_CTRL: begin
                    if (s_q.wstrb[0] && ctrl_ok(s_q.wdata[4:0]) && !eeprom_write_busy && !op_run) begin
                        s_d.ctrl   = s_q.wdata[4:0];
                        s_d.phase  = ST_ARMED;
                        s_d.window = s_q.wdata[4:0] == FSP_CMD_FLREAD ? FSP_LPM_WINDOW : FSP_SPM_WINDOW;
                        buf_clr    = s_q.wdata[FSP_B_CLEAR];
                    end
                end
                FSP_OFS_STATUS, FSP_OFS_PAGE: begin
                    s_d.bresp = FSP_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = FSP_RESP_SLVERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;
        // Register reads
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = FSP_RESP_OKAY;
            s_d.rdata  = '0;
            case (s_axi_araddr)
                FSP_OFS_CTRL: begin
                    s_d.rdata[4:0] = s_q.ctrl;
                end
                FSP_OFS_STATUS: begin
                    s_d.rdata[FSP_S_BUSY]   = op_run;
                    s_d.rdata[FSP_S_ARMED]  = s_q.phase == ST_ARMED;
                    s_d.rdata[FSP_S_EEBUSY] = s_q.ee_busy;
                    s_d.rdata[FSP_S_LOADED] = buf_loaded;
                end
                FSP_OFS_PAGE: begin
                    s_d.rdata[PAGE_BITS-1:0] = s_q.page;
                end
                default: begin
                    s_d.rresp = FSP_RESP_SLVERR;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;
        // EEPROM write discards a partly loaded buffer
        if (eeprom_write_busy && !s_q.ee_busy) begin
            buf_clr = 1'b1;
        end
        // Reset clears the buffer unless a page write still needs it
        if (reset && s_q.phase == ST_WRITE) begin
            buf_clr = buf_clr;
        end else if (reset) begin
            buf_clr = 1'b1;
        end
        // Flash strobes and CPU stall follow the phase
        s_d.erase = s_d.phase == ST_ERASE;
        s_d.write = s_d.phase == ST_WRITE;
        s_d.stall = s_d.erase || s_d.write;
    end

    // ----------------------------------------------------------------
    // State register, an operation survives reset
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset && op_run) begin
            s_q       <= '0;
            s_q.phase <= s_d.phase;
            s_q.ctrl  <= s_d.ctrl;
            s_q.page  <= s_q.page;
            s_q.erase <= s_d.erase;
            s_q.write <= s_d.write;
            s_q.stall <= s_d.stall;
        end else if (reset) begin
            s_q       <= '0;
            s_q.phase <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign s_axi_awready  = s_q.awready;
    assign s_axi_wready   = s_q.wready;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_arready  = s_q.arready;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;
    assign cpu_stall      = s_q.stall;
    assign lpm_data       = s_q.lpm_data;
    assign lpm_fuse_valid = s_q.lpm_valid;
    assign flash_erase    = s_q.erase;
    assign flash_write    = s_q.write;
    assign flash_page     = s_q.page;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_fuse_gate: assert property ($rose(s_q.erase) || $rose(s_q.write) |->
        $past(spm_strobe) && !$past(fuse_high_byte[FSP_FUSE_SPM_BIT]))
        else $error("flash operation started with self-program fuse unprogrammed");
    a_erase_stall: assert property (s_q.erase |-> s_q.stall && !s_q.write)
        else $error("erase without CPU stall");
    a_write_stall: assert property (s_q.write |-> s_q.stall && s_q.ctrl == FSP_CMD_WRITE)
        else $error("write without CPU stall or write code");
    a_op_length: assert property ($rose(s_q.stall) |-> s_q.stall [*8])
        else $error("flash operation ended too early");
    a_window_end: assert property (s_q.phase == ST_ARMED && s_q.window == 3'h1 && !spm_strobe &&
        !lpm_strobe && !wr_go |=> s_q.ctrl == FSP_CTRL_RESET && s_q.phase == ST_IDLE)
        else $error("control bits held after missed window");
    a_write_clears: assert property ($fell(s_q.write) |-> !buf_loaded)
        else $error("buffer kept data after page write");
    a_ee_blocks: assert property ($rose(s_q.stall) || s_q.lpm_valid |-> !$past(eeprom_write_busy))
        else $error("flash access accepted during EEPROM write");
    a_bad_code: assert property (wr_go && s_q.waddr == FSP_OFS_CTRL && !ctrl_ok(s_q.wdata[4:0]) &&
        s_q.phase == ST_IDLE |=> s_q.phase == ST_IDLE && s_q.ctrl == FSP_CTRL_RESET)
        else $error("illegal control code took effect");
    a_lock_read: assert property (lpm_go && z_pointer == FSP_Z_LOCK |=>
        s_q.lpm_valid && s_q.lpm_data == $past(lock_byte) && s_q.phase == ST_IDLE)
        else $error("lock byte read returned wrong value");

    c_erase: cover property ($rose(s_q.erase));
    c_write: cover property ($fell(s_q.write));
    c_load: cover property (buf_wr ##1 buf_loaded);
    c_fuse_read: cover property (s_q.lpm_valid);
endmodule

// ==== dv/fsp_cpu_model.sv ====
`timescale 1ns/1ps
module fsp_cpu_model (
    // Clock
    input  wire logic   mclk,
    // Instruction side
    output logic        spm_strobe,
    output logic        lpm_strobe,
    output logic [15:0] z_pointer,
    output logic [15:0] data_word
);
    // Idle instruction lines
    initial begin
        spm_strobe = 1'b0;
        lpm_strobe = 1'b0;
        z_pointer  = 16'h0000;
        data_word  = 16'h0000;
    end
    // One-cycle instruction; pointer and data scrambled once it is gone
    task automatic issue(input logic load_program_instruction, input logic [15:0] z, input logic [15:0] d);
        spm_strobe <= ~load_program_instruction;
        lpm_strobe <= load_program_instruction;
        z_pointer  <= z;
        data_word  <= d;
        @(posedge mclk);
        spm_strobe <= 1'b0;
        lpm_strobe <= 1'b0;
        z_pointer  <= ~z;
        data_word  <= ~d;
    endtask
endmodule

// ==== dv/flash_self_programming_bench.sv ====
`timescale 1ns/1ps
module flash_self_programming_bench;
    import fsp_pkg::*;
    logic mclk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, spm_strobe, lpm_strobe, cpu_stall;
    logic lpm_fuse_valid, eeprom_write_busy, flash_erase, flash_write;
    logic [7:0] s_axi_awaddr, s_axi_araddr, lpm_data, fuse_low_byte, fuse_high_byte, lock_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, flash_buf_idx;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] z_pointer, data_word, flash_buf_data;
    logic [10:0] flash_page;
    int n_errors = 0, checks_done = 0, cyc = 0, len;
    // Design with shortened operation timer, 17 cycles per operation
    fsp_self_prog #(.TICK_DIV(2), .OP_TICKS(8)) dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .spm_strobe, .lpm_strobe, .z_pointer, .data_word, .cpu_stall, .lpm_data, .lpm_fuse_valid,
        .eeprom_write_busy, .fuse_low_byte, .fuse_high_byte, .lock_byte, .flash_erase, .flash_write,
        .flash_page, .flash_buf_idx, .flash_buf_data);
    fsp_cpu_model cpu (.mclk, .spm_strobe, .lpm_strobe, .z_pointer, .data_word);
    // Clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Control register write; eeprom_write_busy left as the caller set it, response checked as OKAY
    task automatic wr(input logic [4:0] c);
        s_axi_awaddr <= FSP_OFS_CTRL;
        s_axi_wdata <= {27'h0, c};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, FSP_RESP_OKAY);
    endtask
    // Register read; data and response judged at the rvalid edge
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
    endtask
    task automatic ld(input logic [15:0] z, input logic [15:0] d);
        wr(FSP_CMD_LOAD);
        cpu.issue(1'b0, z, d);
    endtask
    task automatic bufchk(input logic [3:0] i, input logic [15:0] e);
        flash_buf_idx <= i;
        repeat (2) @(posedge mclk);
        chk(flash_buf_data, e);
    endtask
    // Erase or write; stall length and page judged
    task automatic op(input logic [4:0] c, input logic [15:0] z);
        wr(c);
        cpu.issue(1'b0, z, 16'h1234);
        len = 0;
        for (int i = 0; i < 5 && cpu_stall !== 1'b1; i++) @(posedge mclk);
        chk({flash_erase, flash_write}, {c == FSP_CMD_ERASE, c == FSP_CMD_WRITE});
        while (cpu_stall === 1'b1) begin
            len++;
            @(posedge mclk);
        end
        chk(len, 17);
        chk(flash_page, z[15:5]);
    endtask
    task automatic fr(input logic [15:0] z, input logic [7:0] e);
        wr(FSP_CMD_FLREAD);
        cpu.issue(1'b1, z, 16'h0);
        @(posedge mclk);
        chk(lpm_fuse_valid, 1'b1);
        chk(lpm_data, e);
    endtask
    // Main sequence: words 3 and 1 loaded out of order, erase before write
    initial begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, eeprom_write_busy, flash_buf_idx} = '0;
        {fuse_low_byte, fuse_high_byte, lock_byte, s_axi_wstrb} = {24'h6aeffc, 4'hf};
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        ld(16'h0126, 16'hbeef);
        ld(16'h0123, 16'h5a5a);
        bufchk(4'h1, 16'h5a5a);
        bufchk(4'h3, 16'hbeef);
        op(FSP_CMD_ERASE, 16'h0126);
        op(FSP_CMD_WRITE, 16'h0120);
        bufchk(4'h3, FSP_ERASED_WORD);
        // Clear command, then EEPROM write discards and blocks loading
        ld(16'h0104, 16'h1111);
        rd(FSP_OFS_STATUS, 32'h8, FSP_RESP_OKAY);
        wr(FSP_CMD_CLEAR);
        bufchk(4'h2, FSP_ERASED_WORD);
        ld(16'h0104, 16'h2222);
        eeprom_write_busy <= 1'b1;
        ld(16'h0106, 16'h3333);
        bufchk(4'h2, FSP_ERASED_WORD);
        bufchk(4'h3, FSP_ERASED_WORD);
        eeprom_write_busy <= 1'b0;
        wr(5'h07);
        rd(FSP_OFS_CTRL, 32'h0, FSP_RESP_OKAY);
        // Reset during an erase leaves it running
        wr(FSP_CMD_ERASE);
        cpu.issue(1'b0, 16'h0140, 16'h0);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        chk({cpu_stall, flash_erase}, 2'h3);
        while (cpu_stall === 1'b1) @(posedge mclk);
        chk(flash_page, 11'h00a);
        fuse_high_byte <= 8'hff;
        ld(16'h0104, 16'h1111);
        bufchk(4'h2, FSP_ERASED_WORD);
        fr(16'h0000, 8'h6a);
        fr(16'h0001, 8'hfc);
        fr(16'h0003, 8'hff);
        rd(8'h40, 32'h0, FSP_RESP_SLVERR);
        close_out();
    end
endmodule
